// ---- src/eepc_ctrl.sv ----
// Program/erase control for on-chip EEPROM and the configuration cell,
// with shared ROM latch control and block protection.
// Assumes one clock (E clock), async low reset, strobe register port.
`include "eepc_map.svh"
`default_nettype none

// What this block does
// - One voltage enable bit powers both ROM and EEPROM programming.
// - ROM latch and EEPROM latch bits are never both set.
// - ROM latch clear gives normal reads; set configures programming paths.
// - Byte bit means byte erase; else row bit row erase; else bulk.
// - Erase bit selects erase instead of program when voltage applies.
// - EEPROM latch set blocks array reads and latches address and data.
// - Voltage enable bit switches array high voltage off or on.
// - Program operations ignore row and byte bits.
// - Bulk erase leaves the configuration cell unchanged.
// - Configuration cell program/erase in any mode only while unprotected.
// - Security active forces single-chip modes, hiding internal buses.
// - Security still gives resident code full EEPROM and RAM access.
// - Setting EEPROM latch and voltage in one write clears both.
// - Protect bits reset to 1, clear only in first 64 cycles or in special modes.
module eepc_ctrl (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   // Register port
   input wire logic [3:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic reg_rd_i,
   output logic [7:0] reg_rdata_o,
   // CPU accesses toward the array
   input wire eepc_pkg::eepc_cpu_t cpu_i,
   // Operating mode
   input wire logic special_mode_i,
   input wire logic expanded_req_i,
   // Array and ROM control
   output eepc_pkg::eepc_op_t ee_op_o,
   output logic ee_read_en_o,
   output logic rom_prog_cfg_o,
   output logic rom_hv_o,
   output logic pump_clock_select_o,
   output logic single_chip_o
);

   logic [7:0] nv_program_control_reg;
   logic [7:0] nv_program_control_next;
   logic [4:0] block_protect_reg;
   logic [1:0] option_reg;
   logic [`EEPC_PROT_WINDOW_W-1:0] win_cnt_reg;
   logic win_open;
   logic [15:0] lat_addr_reg;
   logic [7:0] lat_data_reg;
   logic lat_cfg_reg;
   logic lat_valid_reg;
   logic cpu_blocked;
   logic wr_ctl;
   logic wr_prot;
   logic wr_opt;
   logic ee_lat;
   logic rom_lat;
   eepc_pkg::eepc_erase_t mode_sel;
   eepc_pkg::eepc_op_t op_next;
   logic cpu_capture;
   logic special_mode_sync;
   logic expanded_req_sync;
   logic [7:0] rdata_next;

   // Mode straps arrive from pins, so each passes a three-stage synchroniser
   eepc_sync3 #(
      .RST_VAL(1'b0)
   ) eepc_sync3_special_i (
      .core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i),
      .pin_i(special_mode_i),
      .level_o(special_mode_sync)
   );

   // Resets to the idle strap level so no false change follows reset
   eepc_sync3 #(
      .RST_VAL(1'b1)
   ) eepc_sync3_expanded_i (
      .core_clk_i(core_clk_i),
      .rst_b_i(rst_b_i),
      .pin_i(expanded_req_i),
      .level_o(expanded_req_sync)
   );

   assign wr_ctl = reg_wr_i && (reg_addr_i == `EEPC_OFS_PROG_CTL);
   assign wr_prot = reg_wr_i && (reg_addr_i == `EEPC_OFS_BLOCK_PROT);
   assign wr_opt = reg_wr_i && (reg_addr_i == `EEPC_OFS_OPTION);
   assign ee_lat = nv_program_control_reg[`EEPC_BIT_EE_LAT];
   assign rom_lat = nv_program_control_reg[`EEPC_BIT_ROM_LAT];
   assign win_open = (win_cnt_reg < 7'(`EEPC_PROT_WINDOW_CYC));
   assign cpu_capture = ee_lat && cpu_i.wr && !cpu_blocked
      && !nv_program_control_reg[`EEPC_BIT_PGM];

   // Control register next value with the write-enforcement logic
   always_comb begin
      nv_program_control_next = nv_program_control_reg;
      if (wr_ctl) begin
         nv_program_control_next = reg_wdata_i;
         // Test half-row bits only exist in special modes
         if (!special_mode_sync) begin
            nv_program_control_next[`EEPC_BIT_ODD] = 1'b0;
            nv_program_control_next[`EEPC_BIT_EVEN] = 1'b0;
         end
         if (reg_wdata_i[`EEPC_BIT_EE_LAT] && reg_wdata_i[`EEPC_BIT_PGM]
               && !nv_program_control_reg[`EEPC_BIT_EE_LAT]) begin
            nv_program_control_next[`EEPC_BIT_EE_LAT] = 1'b0;
            nv_program_control_next[`EEPC_BIT_PGM] = 1'b0;
         end
         // Voltage may only come on once a latch is already held
         if (reg_wdata_i[`EEPC_BIT_PGM] && !ee_lat && !rom_lat) begin
            nv_program_control_next[`EEPC_BIT_PGM] = 1'b0;
         end
         // Latch bits frozen by writes that keep voltage on, so no mid-pulse switch
         if (nv_program_control_reg[`EEPC_BIT_PGM] && reg_wdata_i[`EEPC_BIT_PGM]) begin
            nv_program_control_next[`EEPC_BIT_ROM_LAT] = rom_lat;
            nv_program_control_next[`EEPC_BIT_EE_LAT] = ee_lat;
         end
         if (nv_program_control_next[`EEPC_BIT_ROM_LAT]
               && nv_program_control_next[`EEPC_BIT_EE_LAT]) begin
            nv_program_control_next[`EEPC_BIT_ROM_LAT] = 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         nv_program_control_reg <= `EEPC_RST_PROG_CTL;
      end else begin
         nv_program_control_reg <= nv_program_control_next;
      end
   end

   // Protect window counter saturates so the window never reopens
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         win_cnt_reg <= '0;
      end else if (win_open) begin
         win_cnt_reg <= win_cnt_reg + 7'h01;
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         block_protect_reg <= `EEPC_RST_BLOCK_PROT;
      end else if (wr_prot) begin
         if (win_open || special_mode_sync) begin
            block_protect_reg <= reg_wdata_i[4:0];
         end else begin
            block_protect_reg <= block_protect_reg | reg_wdata_i[4:0];
         end
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         option_reg <= `EEPC_RST_OPTION;
      end else if (wr_opt) begin
         option_reg <= reg_wdata_i[1:0];
      end
   end

   // A write is blocked if its target is protected
   always_comb begin
      if (cpu_i.is_cfg) begin
         cpu_blocked = block_protect_reg[`EEPC_BIT_PROT_CFG];
      end else begin
         cpu_blocked = |(cpu_i.block & block_protect_reg[3:0]);
      end
   end

   // A capture only counts for the latch session it was taken in
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         lat_valid_reg <= 1'b0;
      end else if (!ee_lat) begin
         lat_valid_reg <= 1'b0;
      end else if (cpu_capture) begin
         lat_valid_reg <= 1'b1;
      end
   end

   // Address/data capture while latched; voltage-on writes are ignored
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         lat_addr_reg <= 16'h0000;
         lat_data_reg <= 8'h00;
         lat_cfg_reg <= 1'b0;
      end else if (cpu_capture) begin
         lat_addr_reg <= cpu_i.addr;
         lat_data_reg <= cpu_i.data;
         lat_cfg_reg <= cpu_i.is_cfg;
      end
   end

   // Erase mode decode: byte overrides row
   always_comb begin
      if (nv_program_control_reg[`EEPC_BIT_BYTE]) begin
         mode_sel = eepc_pkg::EEPC_ERASE_BYTE;
      end else if (nv_program_control_reg[`EEPC_BIT_ROW]) begin
         mode_sel = eepc_pkg::EEPC_ERASE_ROW;
      end else begin
         mode_sel = eepc_pkg::EEPC_ERASE_BULK;
      end
   end

   always_comb begin
      op_next.hv_on = nv_program_control_reg[`EEPC_BIT_PGM] && ee_lat
         && lat_valid_reg;
      op_next.erase = nv_program_control_reg[`EEPC_BIT_ERASE];
      // Program ignores mode; bulk erase is aimed at the array only
      op_next.mode = op_next.erase ? mode_sel : eepc_pkg::EEPC_ERASE_BYTE;
      op_next.cfg_target = lat_cfg_reg
         && !(op_next.erase && mode_sel == eepc_pkg::EEPC_ERASE_BULK);
      op_next.addr = lat_addr_reg;
      op_next.data = lat_data_reg;
   end

   // Array-facing outputs, all registered
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ee_op_o <= '0;
      end else begin
         ee_op_o <= op_next;
      end
   end

   // Resident code keeps read access whenever unlatched, secure or not
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         ee_read_en_o <= 1'b1;
      end else begin
         ee_read_en_o <= !nv_program_control_next[`EEPC_BIT_EE_LAT];
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rom_prog_cfg_o <= 1'b0;
      end else begin
         rom_prog_cfg_o <= nv_program_control_next[`EEPC_BIT_ROM_LAT];
      end
   end

   // One enable serves both arrays; the ROM side also needs its own latch
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         rom_hv_o <= 1'b0;
      end else begin
         rom_hv_o <= nv_program_control_next[`EEPC_BIT_PGM]
            && nv_program_control_next[`EEPC_BIT_ROM_LAT];
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         pump_clock_select_o <= 1'b0;
      end else begin
         pump_clock_select_o <= option_reg[`EEPC_BIT_PUMP_CLK];
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         single_chip_o <= 1'b0;
      end else begin
         single_chip_o <= option_reg[`EEPC_BIT_SECURE] || !expanded_req_sync;
      end
   end

   // Register read mux; unmapped reads return zero
   always_comb begin
      rdata_next = 8'h00;
      if (reg_addr_i == `EEPC_OFS_PROG_CTL) begin
         rdata_next = nv_program_control_reg;
      end else if (reg_addr_i == `EEPC_OFS_BLOCK_PROT) begin
         rdata_next = {3'h0, block_protect_reg};
      end else if (reg_addr_i == `EEPC_OFS_STATUS) begin
         rdata_next = {4'h0, win_open, lat_cfg_reg, ee_op_o.hv_on, lat_valid_reg};
      end else if (reg_addr_i == `EEPC_OFS_LATCH_ADDR_LO) begin
         rdata_next = lat_addr_reg[7:0];
      end else if (reg_addr_i == `EEPC_OFS_LATCH_ADDR_HI) begin
         rdata_next = lat_addr_reg[15:8];
      end else if (reg_addr_i == `EEPC_OFS_LATCH_DATA) begin
         rdata_next = lat_data_reg;
      end else if (reg_addr_i == `EEPC_OFS_OPTION) begin
         rdata_next = {6'h00, option_reg};
      end
   end

   // Read data stand for one cycle only, then fall back to zero
   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         reg_rdata_o <= 8'h00;
      end else if (reg_rd_i) begin
         reg_rdata_o <= rdata_next;
      end else begin
         reg_rdata_o <= 8'h00;
      end
   end

endmodule

// Three-stage synchroniser for a slow level pin. The held level only moves
// once the second and third stages agree, so a one-cycle glitch that
// slips past the first stage never reaches the control logic.
module eepc_sync3 #(
   parameter logic RST_VAL = 1'b0
) (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   // Pin and held level
   input wire logic pin_i,
   output logic level_o
);

   logic [2:0] stage_reg;

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         stage_reg <= {3{RST_VAL}};
      end else begin
         stage_reg <= {stage_reg[1:0], pin_i};
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_b_i) begin
      if (!rst_b_i) begin
         level_o <= RST_VAL;
      end else if (stage_reg[1] == stage_reg[2]) begin
         level_o <= stage_reg[2];
      end
   end

endmodule
`default_nettype wire

// ---- src/eepc_map.svh ----
// Register offsets, field positions, reset values and timing counts for the
// nonvolatile program/erase control block.
// Assumes a plain strobe register port with 8-bit data.
`ifndef EEPC_MAP_SVH
`define EEPC_MAP_SVH

// Register indices on the local register port
`define EEPC_OFS_PROG_CTL 4'h0
`define EEPC_OFS_BLOCK_PROT 4'h1
`define EEPC_OFS_STATUS 4'h2
`define EEPC_OFS_LATCH_ADDR_LO 4'h3
`define EEPC_OFS_LATCH_ADDR_HI 4'h4
`define EEPC_OFS_LATCH_DATA 4'h5
`define EEPC_OFS_OPTION 4'h6

// Program control fields
`define EEPC_BIT_ODD 7
`define EEPC_BIT_EVEN 6
`define EEPC_BIT_ROM_LAT 5
`define EEPC_BIT_BYTE 4
`define EEPC_BIT_ROW 3
`define EEPC_BIT_ERASE 2
`define EEPC_BIT_EE_LAT 1
`define EEPC_BIT_PGM 0

// Block protect fields
`define EEPC_BIT_PROT_CFG 4

// Option fields
`define EEPC_BIT_PUMP_CLK 0
`define EEPC_BIT_SECURE 1

// Reset values
`define EEPC_RST_PROG_CTL 8'h00
`define EEPC_RST_BLOCK_PROT 5'h1f
`define EEPC_RST_OPTION 2'h0

// Protect window after reset, in clock cycles
`define EEPC_PROT_WINDOW_CYC 64
`define EEPC_PROT_WINDOW_W 7

`endif

// ---- src/eepc_pkg.sv ----
// Types shared by the program/erase control block.
// Assumes eepc_map.svh for numeric constants.
`default_nettype none
package eepc_pkg;

   typedef enum logic [1:0] {
      EEPC_ERASE_BULK,
      EEPC_ERASE_ROW,
      EEPC_ERASE_BYTE
   } eepc_erase_t;

   // Operation handed to the array macro while voltage is on
   typedef struct packed {
      logic hv_on;
      logic erase;
      eepc_erase_t mode;
      logic cfg_target;
      logic [15:0] addr;
      logic [7:0] data;
   } eepc_op_t;

   // CPU write toward array or configuration cell
   typedef struct packed {
      logic wr;
      logic rd;
      logic is_cfg;
      logic [3:0] block;
      logic [15:0] addr;
      logic [7:0] data;
   } eepc_cpu_t;

endpackage
`default_nettype wire

// ---- dv/eepc_ctrl_props.sv ----
// Port assertions for the program/erase control block.
// Assumes the single core clock and the async active-low reset of the top.
`default_nettype none
module eepc_ctrl_props (
   // Clock and reset
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   // Watched inputs
   input wire logic [3:0] reg_addr_i,
   input wire logic [7:0] reg_wdata_i,
   input wire logic reg_wr_i,
   input wire logic expanded_req_i,
   // Watched outputs
   input wire eepc_pkg::eepc_op_t ee_op_o,
   input wire logic ee_read_en_o,
   input wire logic rom_prog_cfg_o,
   input wire logic rom_hv_o,
   input wire logic single_chip_o
);
   default clocking @(posedge core_clk_i); endclocking
   default disable iff (!rst_b_i);
   sequence s_ctl_wr;
      reg_wr_i && reg_addr_i == 4'h0;
   endsequence
   property p_excl;
      !(rom_prog_cfg_o && !ee_read_en_o);
   endproperty
   a_excl: assert property (p_excl) else $error("both latches set");
   property p_both;
      s_ctl_wr ##0 (reg_wdata_i[1:0] == 2'h3 && ee_read_en_o) |=> ee_read_en_o ##1 !ee_op_o.hv_on;
   endproperty
   a_both: assert property (p_both) else $error("latch and voltage kept");
   property p_off;
      s_ctl_wr ##0 reg_wdata_i == 8'h00 |=> ##1 !ee_op_o.hv_on;
   endproperty
   a_off: assert property (p_off) else $error("voltage stayed on");
   property p_rden;
      ee_op_o.hv_on |-> !$past(ee_read_en_o);
   endproperty
   a_rden: assert property (p_rden) else $error("array readable under voltage");
   property p_prog;
      ee_op_o.hv_on && !ee_op_o.erase |-> ee_op_o.mode == eepc_pkg::EEPC_ERASE_BYTE;
   endproperty
   a_prog: assert property (p_prog) else $error("program mode not plain");
   property p_bulk;
      ee_op_o.hv_on && ee_op_o.mode == eepc_pkg::EEPC_ERASE_BULK |-> !ee_op_o.cfg_target;
   endproperty
   a_bulk: assert property (p_bulk) else $error("bulk erase hits config");
   property p_romhv;
      rom_hv_o |-> rom_prog_cfg_o;
   endproperty
   a_romhv: assert property (p_romhv) else $error("rom voltage without latch");
   // The strap passes a three-stage synchroniser before it counts
   sequence s_strap_low;
      !expanded_req_i [*6];
   endsequence
   property p_single;
      s_strap_low |-> single_chip_o;
   endproperty
   a_single: assert property (p_single) else $error("expanded without request");
endmodule
bind eepc_ctrl eepc_ctrl_props eepc_ctrl_props_i (.core_clk_i, .rst_b_i, .reg_addr_i,
   .reg_wdata_i, .reg_wr_i, .expanded_req_i, .ee_op_o, .ee_read_en_o, .rom_prog_cfg_o,
   .rom_hv_o, .single_chip_o);
`default_nettype wire

// ---- dv/eepc_ctrl_bench.sv ----
// Self-checking bench for the program/erase control block.
// Assumes the package, the design and the checker are compiled before it.
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin bad_count++; \
   $display("unexpected %0t got %h exp %h", $time, g, e); end end
module eepc_ctrl_bench;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {logic [7:0] lat, pgm; logic cfg, cfg_exp, ers; eepc_pkg::eepc_erase_t md;}
      eepc_row_t;
   localparam eepc_pkg::eepc_erase_t m_byte = eepc_pkg::EEPC_ERASE_BYTE;
   localparam eepc_pkg::eepc_erase_t m_row = eepc_pkg::EEPC_ERASE_ROW;
   localparam eepc_pkg::eepc_erase_t m_bulk = eepc_pkg::EEPC_ERASE_BULK;
   logic core_clk_i = 0, rst_b_i = 0, reg_wr_i = 0, reg_rd_i = 0, expanded_req_i = 1;
   logic special_mode_i = 0, ee_read_en_o, rom_prog_cfg_o, rom_hv_o;
   logic pump_clock_select_o, single_chip_o;
   logic [3:0] reg_addr_i = 4'h0;
   logic [7:0] reg_wdata_i = 8'h00, reg_rdata_o, d;
   eepc_pkg::eepc_cpu_t cpu_i = '0;
   eepc_pkg::eepc_op_t ee_op_o;
   int bad_count = 0, compares = 0;
   // Latch value, voltage value, config target, expected target, erase, mode
   eepc_row_t rows[10] = '{
      '{8'h02, 8'h03, 0, 0, 0, m_byte},
      '{8'h0a, 8'h0b, 0, 0, 0, m_byte},
      '{8'h06, 8'h07, 0, 0, 1, m_bulk},
      '{8'h0e, 8'h0f, 0, 0, 1, m_row},
      '{8'h16, 8'h17, 0, 0, 1, m_byte},
      '{8'h1e, 8'h1f, 0, 0, 1, m_byte},
      '{8'h02, 8'h03, 1, 1, 0, m_byte},
      '{8'h06, 8'h07, 1, 0, 1, m_bulk},
      '{8'h16, 8'h17, 1, 1, 1, m_byte},
      '{8'h02, 8'h03, 1, 1, 0, m_byte}};
   eepc_ctrl eepc_ctrl_i (.core_clk_i, .rst_b_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
      .reg_rd_i, .reg_rdata_o, .cpu_i, .special_mode_i, .expanded_req_i, .ee_op_o,
      .ee_read_en_o, .rom_prog_cfg_o, .rom_hv_o, .pump_clock_select_o, .single_chip_o);
   initial begin
      forever #5 core_clk_i = ~core_clk_i;
   end
   task automatic wr(input logic [3:0] a, input logic [7:0] v);
      @(posedge core_clk_i);
      reg_wr_i <= 1;
      reg_addr_i <= a;
      reg_wdata_i <= v;
      @(posedge core_clk_i);
      reg_wr_i <= 0;
      #1;
   endtask
   // Read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, output logic [7:0] v);
      @(posedge core_clk_i);
      reg_rd_i <= 1;
      reg_addr_i <= a;
      @(posedge core_clk_i);
      reg_rd_i <= 0;
      #1;
      v = reg_rdata_o;
   endtask
   task automatic cw(input logic cfg, input logic [15:0] a, input logic [7:0] v);
      @(posedge core_clk_i);
      cpu_i <= '{wr: 1, rd: 0, is_cfg: cfg, block: 4'h1, addr: a, data: v};
      @(posedge core_clk_i);
      cpu_i.wr <= 0;
   endtask
   task automatic finish_test();
      if (bad_count == 0 && compares > 0)
         $display("*** PASS ***");
      else
         $display("*** FAIL ***");
      $finish;
   endtask
   initial begin
      #100us;
      bad_count++;
      finish_test();
   end
   initial begin
      repeat (20) @(posedge core_clk_i);
      rst_b_i <= 1;
      rd(4'h1, d);
      `CHK(d, 8'h1f)
      `CHK(ee_read_en_o, 1'b1)
      wr(4'h1, 8'h00);
      rd(4'h1, d);
      `CHK(d, 8'h00)
      foreach (rows[i]) begin
         wr(4'h0, rows[i].lat);
         cw(rows[i].cfg, {8'h01, i[7:0]}, 8'h5a ^ i[7:0]);
         wr(4'h0, rows[i].pgm);
         @(posedge core_clk_i);
         #1;
         `CHK(ee_op_o.hv_on, 1'b1)
         `CHK(ee_op_o.erase, rows[i].ers)
         `CHK(ee_op_o.mode, rows[i].md)
         `CHK(ee_op_o.cfg_target, rows[i].cfg_exp)
         `CHK(ee_op_o.addr, {8'h01, i[7:0]})
         `CHK(ee_op_o.data, 8'h5a ^ i[7:0])
         `CHK(ee_read_en_o, 1'b0)
         wr(4'h0, 8'h00);
         @(posedge core_clk_i);
         #1;
         `CHK(ee_op_o.hv_on, 1'b0)
      end
      wr(4'h0, 8'h03);
      rd(4'h0, d);
      `CHK(d, 8'h00)
      `CHK(ee_read_en_o, 1'b1)
      wr(4'h0, 8'h20);
      `CHK(rom_prog_cfg_o, 1'b1)
      wr(4'h0, 8'h21);
      `CHK(rom_hv_o, 1'b1)
      wr(4'h0, 8'h00);
      `CHK(rom_prog_cfg_o, 1'b0)
      wr(4'h0, 8'h22);
      `CHK(rom_prog_cfg_o, 1'b0)
      `CHK(ee_read_en_o, 1'b0)
      wr(4'h0, 8'h00);
      wr(4'h1, 8'h10);
      wr(4'h1, 8'h00);
      rd(4'h1, d);
      `CHK(d, 8'h10)
      wr(4'h0, 8'h02);
      cw(1, 16'h0000, 8'h33);
      wr(4'h0, 8'h03);
      @(posedge core_clk_i);
      #1;
      `CHK(ee_op_o.hv_on, 1'b0)
      wr(4'h0, 8'h00);
      `CHK(single_chip_o, 1'b0)
      wr(4'h6, 8'h03);
      @(posedge core_clk_i);
      #1;
      `CHK(pump_clock_select_o, 1'b1)
      `CHK(single_chip_o, 1'b1)
      wr(4'h6, 8'h00);
      @(posedge core_clk_i);
      #1;
      `CHK(single_chip_o, 1'b0)
      @(posedge core_clk_i);
      expanded_req_i <= 0;
      // Strap passes a three-stage synchroniser before it counts
      repeat (6) @(posedge core_clk_i);
      #1;
      `CHK(single_chip_o, 1'b1)
      rd(4'hf, d);
      `CHK(d, 8'h00)
      // Reset in mid-run, as after a configuration change
      @(posedge core_clk_i);
      rst_b_i <= 0;
      repeat (2) @(posedge core_clk_i);
      rst_b_i <= 1;
      rd(4'h1, d);
      `CHK(d, 8'h1f)
      `CHK(ee_op_o.hv_on, 1'b0)
      `CHK(ee_read_en_o, 1'b1)
      wr(4'h1, 8'h00);
      rd(4'h1, d);
      `CHK(d, 8'h00)
      // Special mode: protection is rewritable and the cell stays reachable
      @(posedge core_clk_i);
      special_mode_i <= 1;
      repeat (70) @(posedge core_clk_i);
      wr(4'h1, 8'h1f);
      wr(4'h1, 8'h00);
      rd(4'h1, d);
      `CHK(d, 8'h00)
      wr(4'h0, 8'h02);
      cw(1, 16'h0000, 8'h3c);
      wr(4'h0, 8'h03);
      @(posedge core_clk_i);
      #1;
      `CHK(ee_op_o.hv_on, 1'b1)
      `CHK(ee_op_o.cfg_target, 1'b1)
      finish_test();
   end
endmodule
`default_nettype wire
